// ==== design/frs_pkg.sv ====
// Constants and types for the floppy result-status and reset block
//Contract
//[R1] Set first error bit 7 on access past last sector or missing terminal count.
//[R2] Set first error bit 5 on ID-field or data-field CRC failure.
//[R3] Set first error bit 4 when host or DMA service arrives too late.
//[R4] Set first error bit 2 on missing sector, bad ID read, lost sequence.
//[R5] Set first error bit 1 if write-protect high during write or format.
//[R6] First error bit 0: no ID mark within two index pulses, or no data mark.
//[R7] Unused status bits read zero: first 6,3; second 7,3,2; drive 7.
//[R8] Set second error bit 6 when data mark type mismatches the read command.
//[R9] Set second error bit 5 on data-field CRC failure.
//[R10] Set second error bit 4 when ID track differs from internal track.
//[R11] Set second error bit 1 when ID track differs and equals FF hex.
//[R12] Set second error bit 0 when no data or deleted-data mark is found.
//[R13] Drive status bit 6 shows write-protect pin, bit 4 track-zero pin.
//[R14] Drive status bit 2 shows head-select pin, bits 1,0 drive-select pins.
//[R15] Drive status bits 5 and 3 always read one.
//[R16] Pin, control register and rate register resets, plus power-on initialise.
//[R17] Any reset source takes the core out of power-down.
//[R18] Hardware reset aborts all operations and goes idle; writes get corrupted.
//[R19] Reset exit clears internal state and configure settings, awaits command.
//[R20] Drive polling starts after reset unless a new configure disables it.
//[R21] Hardware reset clears all but the specify settings.
//[R22] Hardware reset sets control register reset bit; host must clear it.
//[R23] Status bytes are read as result bytes through the data register.
//[R24] Rate register reset self-clears; control register reset needs a write, wins.
package frs_pkg;
  // First error status byte fields
  localparam int S1_END_TRACK   = 7;
  localparam int S1_CRC         = 5;
  localparam int S1_OVERRUN     = 4;
  localparam int S1_NO_DATA     = 2;
  localparam int S1_NOT_WRITE   = 1;
  localparam int S1_NO_ID_MARK  = 0;
  // Second error status byte fields
  localparam int S2_CTRL_MARK   = 6;
  localparam int S2_DATA_CRC    = 5;
  localparam int S2_WRONG_TRK   = 4;
  localparam int S2_BAD_TRK     = 1;
  localparam int S2_NO_DATA_MK  = 0;
  // Drive status byte fields
  localparam int S3_WPROT       = 6;
  localparam int S3_ONE_HI      = 5;
  localparam int S3_TRACK_ZERO_PIN        = 4;
  localparam int S3_ONE_LO      = 3;
  localparam int S3_HEAD        = 2;
  // Reset values and special figures
  localparam logic [7:0]  STAT_RST      = 8'h00;
  localparam logic [7:0]  DRV_STAT_RST  = 8'h28;
  localparam logic [15:0] SPECIFY_RST   = 16'h0000;
  localparam logic [7:0]  BAD_TRACK_ID  = 8'hFF;
  localparam logic [1:0]  INDEX_LIMIT   = 2'h2;
  // Self-clearing rate register reset pulse
  localparam int CLK_NS          = 50;
  localparam int DSR_PULSE_NS    = 500;
  localparam int DSR_PULSE_CYC   = (DSR_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] DSR_CNT_LOAD = 4'(DSR_PULSE_CYC);
  // Result byte selector
  localparam logic [1:0] RES_ST1 = 2'h1;
  localparam logic [1:0] RES_ST2 = 2'h2;
  localparam logic [1:0] RES_ST3 = 2'h3;
  // Command kinds seen by the status logic
  typedef enum logic [2:0] {
    CMD_OTHER, CMD_READ_DATA, CMD_READ_DEL, CMD_READ_ID,
    CMD_READ_TRACK, CMD_WRITE_DATA, CMD_WRITE_DEL, CMD_FORMAT
  } frs_cmd_t;
endpackage

// ==== design/frs_rst_if.sv ====
// Reset request and reset state signals between top and reset control
`timescale 1ns/10ps
interface frs_rst_if;
  logic hw_req;      // Synchronised pin reset, high while held
  logic dor_wr;
  logic dor_bit;
  logic dsr_wr;
  logic dsr_bit;
  logic pd_req;
  logic core_reset;
  logic hw_pulse;
  logic exit_pulse;
  logic powered_down;
  logic dor_reset;
  modport top (output hw_req, dor_wr, dor_bit, dsr_wr, dsr_bit, pd_req,
               input  core_reset, hw_pulse, exit_pulse, powered_down, dor_reset);
  modport ctl (input  hw_req, dor_wr, dor_bit, dsr_wr, dsr_bit, pd_req,
               output core_reset, hw_pulse, exit_pulse, powered_down, dor_reset);
endinterface

// ==== design/frs_reset_ctl.sv ====
// Reset source arbitration, power-down exit and reset exit detection
`timescale 1ns/10ps
module frs_reset_ctl
  import frs_pkg::*;
(
  // Clock and power-on reset
  input wire logic clk,
  input wire logic rst_n,
  // Request and state bundle
  frs_rst_if.ctl   rif
);
  logic       dor_q;
  logic [3:0] dsr_cnt_q;
  logic       hw_d1_q;
  logic       core_q;
  logic       pd_q;

  // Control register reset bit: pin reset forces it, host write clears
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dor_q <= 1'b1;
    end else if (rif.hw_req) begin
      dor_q <= 1'b1; // [R22]
    end else if (rif.dor_wr) begin
      dor_q <= rif.dor_bit; // [R24]
    end
  end

  // Rate register reset times out by itself
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dsr_cnt_q <= 4'h0;
    end else if (rif.dsr_wr && rif.dsr_bit) begin
      dsr_cnt_q <= DSR_CNT_LOAD; // [R24]
    end else if (dsr_cnt_q != 4'h0) begin
      dsr_cnt_q <= dsr_cnt_q - 4'h1;
    end
  end

  // Edge of pin reset for the abort pulse
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hw_d1_q <= 1'b0;
    end else begin
      hw_d1_q <= rif.hw_req;
    end
  end

  // Core reset level, registered to give a clean exit edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      core_q <= 1'b1; // [R16]
    end else begin
      core_q <= rif.hw_req | dor_q | (dsr_cnt_q != 4'h0); // [R16]
    end
  end

  // Power-down left on any reset source
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pd_q <= 1'b0;
    end else if (core_q) begin
      pd_q <= 1'b0; // [R17]
    end else if (rif.pd_req) begin
      pd_q <= 1'b1;
    end
  end

  assign rif.core_reset   = core_q;
  assign rif.hw_pulse     = rif.hw_req & ~hw_d1_q; // [R18]
  assign rif.exit_pulse   = core_q & ~(rif.hw_req | dor_q | (dsr_cnt_q != 4'h0));
  assign rif.powered_down = pd_q;
  assign rif.dor_reset    = dor_q;
endmodule

// ==== design/frs_top.sv ====
// Result status bytes and reset handling of the floppy controller core
`timescale 1ns/10ps
module frs_top
  import frs_pkg::*;
(
  // Clock and power-on reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Hardware reset pin, active low, asynchronous to clk
  input  wire logic       system_reset_pin_n,
  // Host control writes
  input  wire logic       dor_wr,
  input  wire logic       dor_reset_bit,
  input  wire logic       dsr_wr,
  input  wire logic       dsr_reset_bit,
  input  wire logic       power_down_req,
  input  wire logic       specify_wr,
  input  wire logic [15:0] specify_data,
  input  wire logic       configure_wr,
  input  wire logic       configure_poll_dis,
  // Command engine
  input  wire logic       cmd_start,
  input  wire logic [2:0] cmd_kind,
  input  wire logic       cmd_active,
  input  wire logic       evt_sector_past_end,
  input  wire logic       evt_tc_missing,
  input  wire logic       evt_id_crc_fail,
  input  wire logic       evt_data_crc_fail,
  input  wire logic       evt_overrun,
  input  wire logic       evt_sector_not_found,
  input  wire logic       evt_id_unreadable,
  input  wire logic       evt_sequence_lost,
  input  wire logic       id_search,
  input  wire logic       id_mark_seen,
  input  wire logic       id_valid,
  input  wire logic [7:0] id_track,
  input  wire logic [7:0] cur_track,
  input  wire logic       dam_seen,
  input  wire logic       dam_deleted,
  input  wire logic       dam_missing,
  // Drive cable pins, asynchronous to clk
  input  wire logic       write_protect_pin,
  input  wire logic       track_zero_pin,
  input  wire logic       head_select_pin,
  input  wire logic [1:0] drive_select_pin,
  input  wire logic       index_pulse_pin_n,
  // Result phase data register
  input  wire logic [1:0] result_sel,
  input  wire logic       result_rd,
  output logic      [7:0] result_data,
  // Status and reset state
  output logic      [7:0] first_error_status_byte,
  output logic      [7:0] second_error_status_byte,
  output logic      [7:0] drive_pin_status_byte,
  output logic            core_reset,
  output logic            abort_ops,
  output logic            powered_down,
  output logic            dor_reset_state,
  output logic            polling_en,
  output logic      [15:0] specify_q
);
  localparam int NPIN = 7;

  frs_rst_if rif ();

  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_s1_q;
  logic [NPIN-1:0] pin_s2_q;
  logic            hw_req;
  logic            wp_s;
  logic            track_zero_pin_s;
  logic            head_s;
  logic [1:0]      ds_s;
  logic            index_s;
  logic            index_d_q;
  logic            index_fall;
  logic [1:0]      index_cnt_q;
  logic [7:0]      st1_q;
  logic [7:0]      st1_d;
  logic [7:0]      st2_q;
  logic [7:0]      st2_d;
  logic [7:0]      st3_q;
  logic            clr;
  logic            is_write;
  logic            trk_diff;
  logic            ma_index;
  logic            cm_evt;
  logic            poll_dis_q;
  logic            spec_pin_d_q;
  frs_cmd_t        kind;

  // Command kind decode used by several flags
  function automatic logic cmd_writes(input frs_cmd_t k);
    return (k == CMD_WRITE_DATA) || (k == CMD_WRITE_DEL) || (k == CMD_FORMAT);
  endfunction

  function automatic logic cmd_reads_data(input frs_cmd_t k);
    return (k == CMD_READ_DATA) || (k == CMD_READ_DEL);
  endfunction

  assign kind = frs_cmd_t'(cmd_kind);

  // All cable pins pass two flops before any logic looks at them
  assign pin_raw = {~index_pulse_pin_n, drive_select_pin, head_select_pin,
                    track_zero_pin, write_protect_pin, ~system_reset_pin_n};

  generate
    for (genvar i = 0; i < NPIN; i++) begin : g_sync
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          pin_s1_q[i] <= 1'b0;
          pin_s2_q[i] <= 1'b0;
        end else begin
          pin_s1_q[i] <= pin_raw[i];
          pin_s2_q[i] <= pin_s1_q[i];
        end
      end
    end
  endgenerate

  assign hw_req  = pin_s2_q[0];
  assign wp_s    = pin_s2_q[1];
  assign track_zero_pin_s  = pin_s2_q[2];
  assign head_s  = pin_s2_q[3];
  assign ds_s    = pin_s2_q[5:4];
  assign index_s = pin_s2_q[6];

  // Reset sources feed the reset controller
  assign rif.hw_req  = hw_req; // [R16]
  assign rif.dor_wr  = dor_wr;
  assign rif.dor_bit = dor_reset_bit;
  assign rif.dsr_wr  = dsr_wr;
  assign rif.dsr_bit = dsr_reset_bit;
  assign rif.pd_req  = power_down_req;

  frs_reset_ctl u_rst (
    .clk   (clk),
    .rst_n (rst_n),
    .rif   (rif.ctl)
  );

  assign core_reset      = rif.core_reset;
  assign abort_ops       = rif.core_reset | rif.hw_pulse; // [R18]
  assign powered_down    = rif.powered_down; // [R17]
  assign dor_reset_state = rif.dor_reset; // [R22]

  // Specify settings survive the pin reset; only power-on clears them
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      specify_q <= SPECIFY_RST;
    end else if (specify_wr && !rif.core_reset) begin
      specify_q <= specify_data; // [R21]
    end
  end

  // Delayed abort pulse, a second hook that wipes configure state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      spec_pin_d_q <= 1'b0;
    end else begin
      spec_pin_d_q <= rif.hw_pulse;
    end
  end

  // Configure state wiped on every reset, so polling comes back on
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      poll_dis_q <= 1'b0;
    end else if (rif.core_reset || rif.exit_pulse || spec_pin_d_q) begin
      poll_dis_q <= 1'b0; // [R19]
    end else if (configure_wr) begin
      poll_dis_q <= configure_poll_dis; // [R20]
    end
  end

  assign polling_en = ~rif.core_reset & ~poll_dis_q; // [R20]

  // Index pulse counting while hunting for an ID mark
  assign index_fall = index_s & ~index_d_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      index_d_q <= 1'b0;
    end else begin
      index_d_q <= index_s;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      index_cnt_q <= 2'h0;
    end else if (rif.core_reset || !id_search || id_mark_seen) begin
      index_cnt_q <= 2'h0;
    end else if (index_fall && index_cnt_q != INDEX_LIMIT) begin
      index_cnt_q <= index_cnt_q + 2'h1;
    end
  end

  // Second index pulse with no mark seen is a missing-mark fault
  assign ma_index = id_search & ~id_mark_seen & index_fall
                  & (index_cnt_q == INDEX_LIMIT - 2'h1); // [R6]

  assign is_write = cmd_writes(kind);
  assign trk_diff = id_valid && (id_track != cur_track);
  assign cm_evt   = dam_seen && (((kind == CMD_READ_DATA) && dam_deleted) ||
                    ((kind == CMD_READ_DEL) && !dam_deleted)); // [R8]
  assign clr      = cmd_start | rif.core_reset;

  // First error status: sticky flags, new events beat the command-start clear
  always_comb begin
    st1_d = clr ? STAT_RST : st1_q;
    if (evt_sector_past_end || evt_tc_missing) begin
      st1_d[S1_END_TRACK] = 1'b1; // [R1]
    end
    if (evt_id_crc_fail || evt_data_crc_fail) begin
      st1_d[S1_CRC] = 1'b1; // [R2]
    end
    if (evt_overrun) begin
      st1_d[S1_OVERRUN] = 1'b1; // [R3]
    end
    if ((evt_sector_not_found && cmd_reads_data(kind)) ||
        (evt_id_unreadable && kind == CMD_READ_ID) ||
        (evt_sequence_lost && kind == CMD_READ_TRACK)) begin
      st1_d[S1_NO_DATA] = 1'b1; // [R4]
    end
    if (wp_s && cmd_active && is_write) begin
      st1_d[S1_NOT_WRITE] = 1'b1; // [R5]
    end
    if (ma_index || dam_missing) begin
      st1_d[S1_NO_ID_MARK] = 1'b1; // [R6]
    end
    st1_d[6] = 1'b0; // [R7]
    st1_d[3] = 1'b0; // [R7]
    if (rif.core_reset) begin
      st1_d = STAT_RST; // [R19]
    end
  end

  // Second error status: same sticky scheme
  always_comb begin
    st2_d = clr ? STAT_RST : st2_q;
    if (cm_evt) begin
      st2_d[S2_CTRL_MARK] = 1'b1; // [R8]
    end
    if (evt_data_crc_fail) begin
      st2_d[S2_DATA_CRC] = 1'b1; // [R9]
    end
    if (trk_diff) begin
      st2_d[S2_WRONG_TRK] = 1'b1; // [R10]
    end
    if (trk_diff && id_track == BAD_TRACK_ID) begin
      st2_d[S2_BAD_TRK] = 1'b1; // [R11]
    end
    if (dam_missing) begin
      st2_d[S2_NO_DATA_MK] = 1'b1; // [R12]
    end
    st2_d[7] = 1'b0; // [R7]
    st2_d[3] = 1'b0; // [R7]
    st2_d[2] = 1'b0; // [R7]
    if (rif.core_reset) begin
      st2_d = STAT_RST; // [R19]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st1_q <= STAT_RST;
    end else begin
      st1_q <= st1_d;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st2_q <= STAT_RST;
    end else begin
      st2_q <= st2_d;
    end
  end

  // Drive status mirrors the synchronised cable pins every cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st3_q <= DRV_STAT_RST;
    end else begin
      st3_q         <= 8'h00; // [R7]
      st3_q[S3_WPROT] <= wp_s; // [R13]
      st3_q[S3_TRACK_ZERO_PIN]  <= track_zero_pin_s; // [R13]
      st3_q[S3_ONE_HI] <= 1'b1; // [R15]
      st3_q[S3_ONE_LO] <= 1'b1; // [R15]
      st3_q[S3_HEAD]  <= head_s; // [R14]
      st3_q[1:0]      <= ds_s; // [R14]
    end
  end

  assign first_error_status_byte  = st1_q;
  assign second_error_status_byte = st2_q;
  assign drive_pin_status_byte    = st3_q;

  // Result byte latched on the data register read strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      result_data <= STAT_RST;
    end else if (rif.core_reset) begin
      result_data <= STAT_RST;
    end else if (result_rd) begin
      case (result_sel)
        RES_ST1: result_data <= st1_q; // [R23]
        RES_ST2: result_data <= st2_q; // [R23]
        RES_ST3: result_data <= st3_q; // [R23]
        default: result_data <= STAT_RST;
      endcase
    end
  end
endmodule

// ==== bench/frs_drive_model.sv ====
// Drive cable model: status pins and index pulses seen by the controller
`timescale 1ns/10ps
module frs_drive_model (
  // Clock, reset and requested pin state
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [4:0] pin_req,
  input  wire logic       index_go,
  // Cable pins
  output logic            write_protect_pin,
  output logic            track_zero_pin,
  output logic            head_select_pin,
  output logic [1:0]      drive_select_pin,
  output logic            index_pulse_pin_n
);
  logic [4:0] idx_q;

  // Pins lag the request by a cycle, like a slow cable
  always_ff @(posedge clk) begin
    {write_protect_pin, track_zero_pin, head_select_pin, drive_select_pin} <= pin_req;
  end

  // Two index pulses, four cycles low each, sixteen cycles apart
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idx_q <= 5'h00;
    end else if (index_go) begin
      idx_q <= 5'h1F;
    end else if (idx_q != 5'h00) begin
      idx_q <= idx_q - 5'h01;
    end
  end
  // Only the top four counts of each half are low; idle stays high
  assign index_pulse_pin_n = !(idx_q[3:2] == 2'h3);
endmodule

// ==== bench/frs_assertions.sv ====
// Concurrent checks on the result status and reset ports
`timescale 1ns/10ps
module frs_checker (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // Stimulus at the ports
  input wire logic        dor_wr,
  input wire logic        dor_reset_bit,
  input wire logic        evt_sector_past_end,
  input wire logic        evt_data_crc_fail,
  input wire logic        evt_overrun,
  input wire logic        id_valid,
  input wire logic [7:0]  id_track,
  input wire logic [7:0]  cur_track,
  input wire logic        write_protect_pin,
  input wire logic        track_zero_pin,
  // Outputs under watch
  input wire logic [7:0]  first_error_status_byte,
  input wire logic [7:0]  second_error_status_byte,
  input wire logic [7:0]  drive_pin_status_byte,
  input wire logic        core_reset,
  input wire logic        abort_ops,
  input wire logic        dor_reset_state,
  input wire logic        polling_en,
  input wire logic [15:0] specify_q
);
  wire [7:0] s1 = first_error_status_byte;
  wire [7:0] s2 = second_error_status_byte;
  wire [7:0] s3 = drive_pin_status_byte;
  logic [2:0] up_q;

  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // Cycles since reset release, so the pin synchronisers have settled
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      up_q <= 3'h0;
    end else if (up_q != 3'h7) begin
      up_q <= up_q + 3'h1;
    end
  end

  a_unused_zero: assert property (!(s1[6] | s1[3] | s2[7] | s2[3] | s2[2] | s3[7]))
    else $error("unused status bit set");
  a_fixed_ones: assert property (s3[5] && s3[3])
    else $error("drive byte fixed ones missing");
  a_end_track: assert property (evt_sector_past_end && !core_reset |=> s1[7])
    else $error("end of track flag not set");
  a_crc_flags: assert property (evt_data_crc_fail && !core_reset |=> s1[5] && s2[5])
    else $error("data crc flags not set");
  a_overrun_flag: assert property (evt_overrun && !core_reset |=> s1[4])
    else $error("overrun flag not set");
  a_bad_track: assert property (id_valid && id_track == 8'hFF && !core_reset
    && cur_track != 8'hFF |=> s2[4] && s2[1]) else $error("bad track flags not set");
  a_pin_mirror: assert property ((up_q == 3'h7 && !core_reset && $stable(track_zero_pin)
    && $stable(write_protect_pin)) [*4] |-> s3[4] == track_zero_pin
    && s3[6] == write_protect_pin) else $error("drive byte does not follow pins");
  a_dor_hold: assert property (dor_wr && dor_reset_bit |=> dor_reset_state
    ##1 core_reset) else $error("control reset bit did not hold reset");
  a_specify_kept: assert property (core_reset |=> $stable(specify_q))
    else $error("specify settings changed in reset");
  a_reset_gates: assert property (core_reset |-> abort_ops && !polling_en)
    else $error("reset does not abort or stop polling");
  a_status_clear: assert property (core_reset [*2] |-> s1 == 8'h00 && s2 == 8'h00)
    else $error("error bytes not cleared in reset");
  c_release: cover property (dor_wr && !dor_reset_bit);
  c_bad_track: cover property (s2[1]);
  c_reset_rise: cover property ($rose(core_reset));
endmodule

bind frs_top frs_checker frs_checker_inst (
  .clk, .rst_n, .dor_wr, .dor_reset_bit, .evt_sector_past_end, .evt_data_crc_fail,
  .evt_overrun, .id_valid, .id_track, .cur_track, .write_protect_pin, .track_zero_pin,
  .first_error_status_byte, .second_error_status_byte, .drive_pin_status_byte,
  .core_reset, .abort_ops, .dor_reset_state, .polling_en, .specify_q
);

// ==== bench/frs_tb.sv ====
// Self-checking bench for the result status and reset block
`timescale 1ns/10ps
module frs_tb_top;
  import frs_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, system_reset_pin_n = 1'b1, dor_wr = 1'b0, result_rd = 1'b0;
  logic dor_reset_bit = 1'b0, dsr_wr = 1'b0, dsr_reset_bit = 1'b0, power_down_req = 1'b0;
  logic specify_wr = 1'b0, configure_wr = 1'b0, configure_poll_dis = 1'b0, cmd_start = 1'b0;
  logic cmd_active = 1'b0, id_search = 1'b0, index_go = 1'b0, id_mark_seen = 1'b0;
  logic [15:0] specify_data = 16'h0000;
  logic [2:0]  cmd_kind = 3'h0;
  logic [11:0] ev = 12'h000;
  logic [7:0]  id_track = 8'h03, cur_track = 8'h03;
  logic [4:0]  pin_req = 5'h00;
  logic [1:0]  result_sel = 2'h0;
  wire [7:0]   result_data, s1, s2, s3;
  wire [1:0]   drive_select_pin;
  wire [15:0]  specify_q;
  wire core_reset, abort_ops, powered_down, dor_reset_state, polling_en;
  wire write_protect_pin, track_zero_pin, head_select_pin, index_pulse_pin_n;
  int n_errors = 0, compares = 0;
  // Event word, high to low: past end, no count, ID crc, data crc, overrun,
  // not found, bad ID, lost sequence, no data mark, mark seen, deleted, ID valid
  logic [11:0] t_ev [13] = '{12'h800, 12'h400, 12'h200, 12'h100, 12'h080, 12'h040,
    12'h020, 12'h010, 12'h008, 12'h006, 12'h004, 12'h001, 12'h001};
  logic [2:0] t_kind [13] = '{3'h0, 3'h1, 3'h0, 3'h0, 3'h0, 3'h1, 3'h3, 3'h4, 3'h0,
    3'h1, 3'h2, 3'h0, 3'h0};
  logic [7:0] t_s1 [13] = '{8'h80, 8'h80, 8'h20, 8'h20, 8'h10, 8'h04, 8'h04, 8'h04,
    8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] t_s2 [13] = '{8'h00, 8'h00, 8'h00, 8'h20, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h01, 8'h40, 8'h40, 8'h10, 8'h12};

  frs_top frs_top_inst (
    .clk, .rst_n, .system_reset_pin_n, .dor_wr, .dor_reset_bit, .dsr_wr, .dsr_reset_bit,
    .power_down_req, .specify_wr, .specify_data, .configure_wr, .configure_poll_dis,
    .cmd_start, .cmd_kind, .cmd_active, .evt_sector_past_end(ev[11]),
    .evt_tc_missing(ev[10]), .evt_id_crc_fail(ev[9]), .evt_data_crc_fail(ev[8]),
    .evt_overrun(ev[7]), .evt_sector_not_found(ev[6]), .evt_id_unreadable(ev[5]),
    .evt_sequence_lost(ev[4]), .id_search, .id_mark_seen, .id_valid(ev[0]),
    .id_track, .cur_track, .dam_seen(ev[2]), .dam_deleted(ev[1]), .dam_missing(ev[3]),
    .write_protect_pin, .track_zero_pin, .head_select_pin, .drive_select_pin,
    .index_pulse_pin_n, .result_sel, .result_rd, .result_data,
    .first_error_status_byte(s1), .second_error_status_byte(s2),
    .drive_pin_status_byte(s3), .core_reset, .abort_ops, .powered_down,
    .dor_reset_state, .polling_en, .specify_q
  );
  frs_drive_model frs_drive_model_inst (
    .clk, .rst_n, .pin_req, .index_go, .write_protect_pin, .track_zero_pin,
    .head_select_pin, .drive_select_pin, .index_pulse_pin_n
  );
  // 20 MHz clock
  initial begin
    forever #25 clk = ~clk;
  end

  // Inputs always move 1 ns after the edge, clear of sampling
  task automatic tick(int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk1(string what, logic exp, logic got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic chkw(string what, logic [15:0] exp, logic [15:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rd_res(logic [1:0] s, logic [7:0] exp);
    result_sel = s;
    result_rd = 1'b1;
    tick();
    result_rd = 1'b0;
    chkw("result byte", {8'h00, exp}, {8'h00, result_data});
  endtask
  task automatic new_cmd(logic [2:0] k);
    cmd_kind = k;
    cmd_start = 1'b1;
    tick();
    cmd_start = 1'b0;
  endtask
  task automatic release_dor();
    dor_wr = 1'b1;
    dor_reset_bit = 1'b0;
    tick();
    dor_wr = 1'b0;
    tick();
  endtask
  task automatic finish_test();
    if (n_errors == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Power-on leaves the core held until the host clears the control bit
  task automatic t_boot();
    chk1("core_reset", 1'b1, core_reset);
    chk1("polling_en", 1'b0, polling_en);
    chkw("drive byte", 16'h0028, {8'h00, s3});
    release_dor();
    chk1("core_reset", 1'b0, core_reset);
    chk1("polling_en", 1'b1, polling_en);
  endtask
  // Each fault alone, fresh command each time, read back as result bytes
  task automatic t_events();
    cmd_active = 1'b1;
    for (int i = 0; i < 13; i++) begin
      new_cmd(t_kind[i]);
      id_track = (i == 12) ? 8'hFF : (i == 11) ? 8'h05 : 8'h03;
      ev = t_ev[i];
      tick();
      ev = 12'h000;
      rd_res(2'h1, t_s1[i]);
      rd_res(2'h2, t_s2[i]);
    end
    cmd_active = 1'b0;
  endtask
  // Two opposite pin patterns on the drive byte
  task automatic t_drive();
    logic [4:0] p;
    for (int i = 0; i < 2; i++) begin
      p = (i == 0) ? 5'h15 : 5'h0A;
      pin_req = p;
      tick(6);
      rd_res(2'h3, {1'b0, p[4], 1'b1, p[3], 1'b1, p[2:0]});
    end
    pin_req = 5'h00;
  endtask
  // Protect pin rising in every command kind but CMD_OTHER; only writes and format flag it
  task automatic t_wprot();
    for (int k = 1; k < 8; k++) begin
      new_cmd(3'(k));
      cmd_active = 1'b1;
      tick();
      pin_req = 5'h10;
      tick(6);
      rd_res(2'h1, (k >= 5) ? 8'h02 : 8'h00);
      cmd_active = 1'b0;
      pin_req = 5'h00;
      tick(6);
    end
  endtask
  // Second index pulse flags the missing mark, unless a mark came between
  task automatic t_index();
    for (int i = 0; i < 2; i++) begin
      new_cmd(3'h3);
      id_search = 1'b1;
      index_go = 1'b1;
      tick();
      index_go = 1'b0;
      tick(12);
      rd_res(2'h1, 8'h00);
      id_mark_seen = (i == 0);
      tick();
      id_mark_seen = 1'b0;
      tick(23);
      rd_res(2'h1, {7'h00, i == 1});
      id_search = 1'b0;
    end
  endtask
  // Rate register reset clears itself; control bit reset outlasts it
  task automatic t_dsr();
    int n = 0;
    power_down_req = 1'b1;
    ev = 12'h080;
    tick();
    power_down_req = 1'b0;
    ev = 12'h000;
    tick();
    chk1("powered_down", 1'b1, powered_down);
    dsr_wr = 1'b1;
    dsr_reset_bit = 1'b1;
    tick();
    dsr_wr = 1'b0;
    tick();
    chk1("core_reset", 1'b1, core_reset);
    while (core_reset === 1'b1 && n < 40) begin
      tick();
      n++;
    end
    chk1("self clear span", 1'b1, n >= DSR_PULSE_CYC - 2 && n <= DSR_PULSE_CYC + 1);
    chk1("powered_down", 1'b0, powered_down);
    rd_res(2'h1, 8'h00);
    dor_wr = 1'b1;
    dor_reset_bit = 1'b1;
    dsr_wr = 1'b1;
    tick();
    dor_wr = 1'b0;
    dsr_wr = 1'b0;
    tick(20);
    chk1("core_reset", 1'b1, core_reset);
    release_dor();
    chk1("core_reset", 1'b0, core_reset);
  endtask
  // Pin reset keeps specify, drops configure, needs the host to release it
  task automatic t_pin();
    specify_data = 16'hA5C3;
    specify_wr = 1'b1;
    tick();
    specify_wr = 1'b0;
    configure_wr = 1'b1;
    configure_poll_dis = 1'b1;
    tick();
    configure_wr = 1'b0;
    chk1("polling_en", 1'b0, polling_en);
    power_down_req = 1'b1;
    tick();
    power_down_req = 1'b0;
    system_reset_pin_n = 1'b0;
    tick(2);
    chk1("abort_ops", 1'b1, abort_ops);
    tick(3);
    chk1("powered_down", 1'b0, powered_down);
    chk1("dor_reset_state", 1'b1, dor_reset_state);
    specify_data = 16'h1234;
    specify_wr = 1'b1;
    tick();
    specify_wr = 1'b0;
    system_reset_pin_n = 1'b1;
    tick(4);
    chkw("specify_q", 16'hA5C3, specify_q);
    chk1("core_reset", 1'b1, core_reset);
    release_dor();
    chk1("polling_en", 1'b1, polling_en);
  endtask
  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    #1;
    rst_n = 1'b1;
    tick();
    t_boot();
    t_events();
    t_drive();
    t_wprot();
    t_index();
    t_dsr();
    t_pin();
    finish_test();
  end
  // Watchdog, far beyond the roughly 320 cycles the tests need
  initial begin
    #500000;
    n_errors++;
    finish_test();
  end
endmodule
